// ---- hdl/ssr_top.sv ----
/*
 start/stop/run-enable logic for the second external location of a drive.
 assumes all inputs are synchronous to SYS_CLK and configuration is quasi-static.
*/
// Function
// - the start command is edge-triggered when the trigger setting is 0 and level-triggered when 1, level by default.
// - the trigger setting is ignored when the command scheme uses pulse-type starts.
// - sources one to three come from independent selectors of one choice set, two and three default to off.
// - with stop method 0, the default, losing run-enable switches the power stage off at once so the motor coasts.
// - with stop method 1, losing run-enable stops the motor along the active deceleration ramp.
// - with stop method 2, losing run-enable stops the motor at the torque limits.
// - run-enable is on when its source reads 1, starts are refused while it is off, and it defaults to selected.
// - run-enable dropping while running begins a stop by the chosen stop method.
// - in the pulse scheme a rising source one starts forward and a rising source two starts reverse, only while source three is 1.
// - start-enable off blocks new starts but does not stop a running motor.
`timescale 1ns/100ps
`default_nettype none
module ssr_top
    import ssr_pkg::*;
(
    input  wire logic                 SYS_CLK,
    input  wire logic                 RST,
    input  wire logic                 CLK_EN,
    input  wire logic [5:0]           SRC1_SEL,
    input  wire logic [5:0]           SRC2_SEL,
    input  wire logic [5:0]           SRC3_SEL,
    input  wire logic [5:0]           RUN_EN_SEL,
    input  wire logic [5:0]           START_EN_SEL,
    input  wire logic [1:0]           CMD_SCHEME,
    input  wire logic                 TRIG_LEVEL,
    input  wire logic [1:0]           STOP_METHOD,
    input  wire logic [SSR_DIN_W-1:0] DIN,
    input  wire logic [SSR_SUP_W-1:0] SUP,
    input  wire logic                 FB_BIT3,
    input  wire logic                 STOP_DONE,
    output logic                      RUN,
    output logic                      REVERSE,
    output logic                      MODULATE,
    output logic                      RAMP_STOP,
    output logic                      TORQUE_STOP,
    output logic                      RUN_EN_OK
);
    logic [4:0] sel_bits;
    logic [5:0] sel_code [5];
    logic [4:0] smp_q;
    logic       src1_q;
    logic       src2_q;
    logic       smp_valid_q;
    ssr_state_t state_q;
    ssr_state_t state_d;
    logic       rev_q;
    logic       rev_d;
    logic [1:0] stop_how_q;
    logic [1:0] stop_how_d;

    assign sel_code[0] = SRC1_SEL;
    assign sel_code[1] = SRC2_SEL;
    assign sel_code[2] = SRC3_SEL;
    assign sel_code[3] = RUN_EN_SEL;
    assign sel_code[4] = START_EN_SEL;

    // independent selectors over one choice set
    for (genvar i = 0; i < 5; i++) begin : g_sel
        ssr_src_sel u_sel (
            .sel   (sel_code[i]),
            .din   (DIN),
            .sup   (SUP),
            .fb3   (FB_BIT3),
            .bit_o (sel_bits[i])
        );
    end

    // sample once per cycle, keep previous for edges
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            smp_q       <= 5'h00;
            src1_q      <= 1'b0;
            src2_q      <= 1'b0;
            smp_valid_q <= 1'b0;
        end else if (CLK_EN) begin
            smp_q       <= sel_bits;
            src1_q      <= smp_q[0];
            src2_q      <= smp_q[1];
            smp_valid_q <= 1'b1;
        end
    end

    logic s1;
    logic s2;
    logic s3;
    logic run_en;
    logic start_en;
    logic rise1;
    logic rise2;
    logic pulse_mode;
    logic lvl_start;
    logic lvl_start_edge;
    logic start_req;
    logic start_rev;
    logic stop_req;
    logic start_ok;
    assign s1       = smp_q[0];
    assign s2       = smp_q[1];
    assign s3       = smp_q[2];
    assign run_en   = smp_q[3] && smp_valid_q; // on when source reads 1
    assign start_en = smp_q[4];
    assign rise1    = s1 && !src1_q && smp_valid_q;
    assign rise2    = s2 && !src2_q && smp_valid_q;
    assign pulse_mode = (CMD_SCHEME == SSR_CMD_PULSE);
    // level scheme: src1 start, src2 direction
    assign lvl_start      = s1;
    assign lvl_start_edge = rise1;
    // edge or level trigger, ignored in pulse scheme
    assign start_req = pulse_mode ? (s3 && (rise1 || rise2)) :
                       (TRIG_LEVEL == SSR_TRIG_LVL) ? lvl_start : lvl_start_edge;
    assign start_rev = pulse_mode ? (rise2 && !rise1) : s2;
    assign stop_req  = pulse_mode ? !s3 : !s1;
    // starts need run-enable and start-enable
    assign start_ok  = start_req && run_en && start_en;

    always_comb begin
        state_d    = state_q;
        rev_d      = rev_q;
        stop_how_d = stop_how_q;
        case (state_q)
            SSR_IDLE: begin
                if (start_ok) begin
                    state_d = SSR_RUN;
                    rev_d   = start_rev;
                end
            end
            SSR_RUN: begin
                // start-enable is not checked here
                if (!run_en) begin
                    state_d    = SSR_STOPPING;
                    stop_how_d = STOP_METHOD;
                end else if (stop_req) begin
                    state_d    = SSR_STOPPING;
                    stop_how_d = SSR_STOP_RAMP;
                end
            end
            SSR_STOPPING: begin
                if (stop_how_q == SSR_STOP_COAST || STOP_DONE) begin
                    state_d = SSR_IDLE;
                end
            end
            default: state_d = SSR_IDLE;
        endcase
    end

    logic coast_now;
    assign coast_now = (state_d == SSR_STOPPING) && (stop_how_d == SSR_STOP_COAST);

    // decisions applied the cycle after sampling
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            state_q     <= SSR_IDLE;
            rev_q       <= 1'b0;
            stop_how_q  <= SSR_STOP_COAST;
            RUN         <= 1'b0;
            REVERSE     <= 1'b0;
            MODULATE    <= 1'b0;
            RAMP_STOP   <= 1'b0;
            TORQUE_STOP <= 1'b0;
            RUN_EN_OK   <= 1'b0;
        end else if (CLK_EN) begin
            state_q     <= state_d;
            rev_q       <= rev_d;
            stop_how_q  <= stop_how_d;
            RUN         <= (state_d == SSR_RUN);
            REVERSE     <= rev_d;
            // power stage off at once on coast
            MODULATE    <= (state_d == SSR_RUN) || ((state_d == SSR_STOPPING) && !coast_now);
            RAMP_STOP   <= (state_d == SSR_STOPPING) && (stop_how_d == SSR_STOP_RAMP);
            TORQUE_STOP <= (state_d == SSR_STOPPING) && (stop_how_d == SSR_STOP_TORQUE);
            RUN_EN_OK   <= run_en;
        end
    end
endmodule // ssr_top
`default_nettype wire

// ---- hdl/ssr_pkg.sv ----
/*
 package for the start/stop/run-enable logic of the second external location:
 source selector codes, command schemes, stop methods, reset values.
 assumes a single control clock.
*/
package ssr_pkg;
    // source selector codes
    localparam logic [5:0] SSR_SRC_OFF   = 6'h00;
    localparam logic [5:0] SSR_SRC_ON    = 6'h01;
    localparam logic [5:0] SSR_SRC_DIN0  = 6'h02;
    localparam int         SSR_DIN_W     = 5;
    localparam logic [5:0] SSR_SRC_SUP0  = 6'h18;
    localparam int         SSR_SUP_W     = 6;
    localparam logic [5:0] SSR_SRC_FB3   = 6'h20;
    // command schemes
    localparam logic [1:0] SSR_CMD_LEVEL = 2'h0;
    localparam logic [1:0] SSR_CMD_PULSE = 2'h1;
    // trigger setting
    localparam logic       SSR_TRIG_EDGE = 1'b0;
    localparam logic       SSR_TRIG_LVL  = 1'b1;
    // stop methods
    localparam logic [1:0] SSR_STOP_COAST  = 2'h0;
    localparam logic [1:0] SSR_STOP_RAMP   = 2'h1;
    localparam logic [1:0] SSR_STOP_TORQUE = 2'h2;
    // reset values
    localparam logic [5:0] SSR_RST_SRC1  = SSR_SRC_OFF;
    localparam logic [5:0] SSR_RST_SRC2  = SSR_SRC_OFF;
    localparam logic [5:0] SSR_RST_SRC3  = SSR_SRC_OFF;
    localparam logic [5:0] SSR_RST_RUNEN = SSR_SRC_ON;
    localparam logic [5:0] SSR_RST_STEN  = SSR_SRC_ON;
    typedef enum logic [1:0] {SSR_IDLE, SSR_RUN, SSR_STOPPING} ssr_state_t;
endpackage

// ---- hdl/ssr_src_sel.sv ----
/*
 one source selector: maps a selector code onto a bit of the input pool.
 assumes pool inputs are synchronous to the clock.
*/
`timescale 1ns/100ps
`default_nettype none
module ssr_src_sel
    import ssr_pkg::*;
(
    input  wire logic [5:0]           sel,
    input  wire logic [SSR_DIN_W-1:0] din,
    input  wire logic [SSR_SUP_W-1:0] sup,
    input  wire logic                 fb3,
    output logic                      bit_o
);
    logic [5:0] din_idx;
    logic [5:0] sup_idx;
    logic       is_din;
    logic       is_sup;
    assign din_idx = sel - SSR_SRC_DIN0;
    assign sup_idx = sel - SSR_SRC_SUP0;
    assign is_din  = (sel >= SSR_SRC_DIN0) && (din_idx < 6'(SSR_DIN_W));
    assign is_sup  = (sel >= SSR_SRC_SUP0) && (sup_idx < 6'(SSR_SUP_W));
    assign bit_o   = (sel == SSR_SRC_ON)  ? 1'b1 :
                     (sel == SSR_SRC_FB3) ? fb3 :
                     is_din ? din[din_idx[2:0]] :
                     is_sup ? sup[sup_idx[2:0]] : 1'b0;
endmodule // ssr_src_sel
`default_nettype wire

// ---- dv/ssr_asserts.sv ----
/*
 port checker for the start/stop/run-enable logic.
 assumes it is bound to ssr_top and CLK_EN is held high.
*/
`timescale 1ns/100ps
`default_nettype none
module ssr_asserts
    import ssr_pkg::*;
(
    input wire logic       SYS_CLK,
    input wire logic       RST,
    input wire logic [5:0] START_EN_SEL,
    input wire logic [1:0] STOP_METHOD,
    input wire logic       STOP_DONE,
    input wire logic       RUN,
    input wire logic       REVERSE,
    input wire logic       MODULATE,
    input wire logic       RAMP_STOP,
    input wire logic       TORQUE_STOP,
    input wire logic       RUN_EN_OK
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    // run-enable loss is seen at the edge where the sampled flag and RUN both fall
    sequence s_loss;
        $past(RUN) && $fell(RUN_EN_OK);
    endsequence
    a_coast_loss: assert property (
        s_loss ##0 $past(STOP_METHOD) == SSR_STOP_COAST |-> !RUN && !MODULATE)
        else $error("no coast");
    a_ramp_loss: assert property (
        s_loss ##0 $past(STOP_METHOD) == SSR_STOP_RAMP |-> !RUN && RAMP_STOP && MODULATE)
        else $error("no ramp");
    a_torque_loss: assert property (
        s_loss ##0 $past(STOP_METHOD) == SSR_STOP_TORQUE |-> !RUN && TORQUE_STOP && MODULATE)
        else $error("no torque");
    a_no_start: assert property (
        !RUN_EN_OK && !$past(RUN) |-> !RUN) else $error("start without run enable");
    a_start_gate: assert property (
        START_EN_SEL == SSR_SRC_OFF ##1 !RUN |=> !RUN) else $error("start without start enable");
    a_run_mod: assert property (
        RUN |-> MODULATE && !RAMP_STOP && !TORQUE_STOP) else $error("run flags wrong");
    a_rev_hold: assert property (
        RUN && $past(RUN) |-> REVERSE == $past(REVERSE)) else $error("direction changed");
    a_ramp_end: assert property (
        RAMP_STOP && STOP_DONE |-> ##[1:2] !RAMP_STOP) else $error("ramp stop stuck");
endmodule // ssr_asserts
`default_nettype wire

// ---- dv/ssr_src_model.sv ----
/*
 command source model: input pool bits and stop feedback of motor control.
 assumes the bench calls put between clock edges only through this task.
*/
`timescale 1ns/100ps
`default_nettype none
module ssr_src_model (
    input  wire logic  clk,
    input  wire logic  stopping,
    output logic [11:0] pool,
    output logic       stop_done
);
    int lat = 4;
    int cnt = 0;
    initial pool = 12'h000;
    always @(posedge clk) cnt <= stopping ? cnt + 1 : 0;
    assign stop_done = stopping && (cnt >= lat);
    task automatic put(input int idx, input logic v);
        @(posedge clk);
        #1 pool[idx] = v;
    endtask
endmodule // ssr_src_model
`default_nettype wire

// ---- dv/tb.sv ----
/*
 testbench for ssr_top: pulse and level schemes, stop methods, start gating.
 assumes ssr_src_model and ssr_asserts are compiled alongside.
*/
`timescale 1ns/100ps
`default_nettype none
module tb
    import ssr_pkg::*;
;
    logic        sys_clk = 1'b0;
    logic        rst     = 1'b1;
    logic [5:0]  st_sel  = SSR_SRC_ON;
    logic [1:0]  scheme  = SSR_CMD_PULSE;
    logic        trig    = SSR_TRIG_LVL;
    logic [1:0]  meth    = SSR_STOP_COAST;
    logic [11:0] pool;
    logic        stop_done, run, rev, mod_o, ramp, torq, en_ok;
    int          fails   = 0;
    int          tests_run = 0;
    always #5 sys_clk = ~sys_clk;
    ssr_src_model src_u (.clk(sys_clk), .stopping(ramp | torq), .pool(pool),
        .stop_done(stop_done));
    ssr_top dut_u (.SYS_CLK(sys_clk), .RST(rst), .CLK_EN(1'b1), .SRC1_SEL(SSR_SRC_DIN0),
        .SRC2_SEL(6'h03), .SRC3_SEL(SSR_SRC_SUP0), .RUN_EN_SEL(SSR_SRC_FB3),
        .START_EN_SEL(st_sel), .CMD_SCHEME(scheme), .TRIG_LEVEL(trig), .STOP_METHOD(meth),
        .DIN(pool[4:0]), .SUP(pool[10:5]), .FB_BIT3(pool[11]), .STOP_DONE(stop_done),
        .RUN(run), .REVERSE(rev), .MODULATE(mod_o), .RAMP_STOP(ramp), .TORQUE_STOP(torq),
        .RUN_EN_OK(en_ok));
    task automatic chk(input logic seen, input logic exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: output mismatch", $time);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic idle_wait;
        for (int i = 0; i < 50 && mod_o !== 1'b0; i++) step(1);
        if (mod_o !== 1'b0) begin
            fails++;
            report_and_stop();
        end
    endtask
    initial begin
        step(20);
        rst = 1'b0;
        src_u.put(5, 1'b1);
        src_u.put(11, 1'b1);
        for (int m = 0; m < 3; m++) begin
            meth = m[1:0];
            src_u.lat = 4 + 2 * m;
            src_u.put(m == 1 ? 1 : 0, 1'b1);
            step(3);
            chk(run, 1'b1);
            chk(rev, m == 1);
            src_u.put(11, 1'b0);
            step(3);
            chk(run, 1'b0);
            chk(en_ok, 1'b0);
            chk(mod_o, m != 0);
            chk(ramp, m == 1);
            chk(torq, m == 2);
            idle_wait();
            src_u.put(11, 1'b1);
            step(3);
            chk(run, 1'b0); // held source gives no restart
            src_u.put(m == 1 ? 1 : 0, 1'b0);
        end
        src_u.put(11, 1'b0);
        src_u.put(0, 1'b1);
        step(3);
        chk(run, 1'b0);
        src_u.put(0, 1'b0);
        src_u.put(11, 1'b1);
        st_sel = SSR_SRC_OFF;
        src_u.put(0, 1'b1);
        step(3);
        chk(run, 1'b0);
        src_u.put(0, 1'b0);
        st_sel = SSR_SRC_ON;
        src_u.put(0, 1'b1);
        step(3);
        st_sel = SSR_SRC_OFF;
        step(4);
        chk(run, 1'b1); // running motor keeps going
        st_sel = SSR_SRC_ON;
        src_u.put(11, 1'b0);
        step(3);
        idle_wait();
        scheme = SSR_CMD_LEVEL;
        for (int t = 0; t < 2; t++) begin
            trig = t[0];
            src_u.put(11, 1'b1);
            step(3);
            chk(run, t[0]);
            src_u.put(11, 1'b0);
            step(3);
            idle_wait();
        end
        trig = SSR_TRIG_EDGE;
        src_u.put(0, 1'b0);
        src_u.put(11, 1'b1);
        src_u.put(0, 1'b1);
        step(3);
        chk(run, 1'b1);
        chk(rev, 1'b0);
        chk(en_ok, 1'b1);
        src_u.put(0, 1'b0);
        step(3);
        chk(run, 1'b0);
        chk(ramp, 1'b1);
        idle_wait();
        report_and_stop();
    end
endmodule // tb
bind ssr_top ssr_asserts chk_u (.*);
`default_nettype wire
